//--- src/aldfc_debounce.sv
`timescale 1ns/10ps
`default_nettype none
module aldfc_debounce (
   input  wire logic                            pclk,    // clock
   input  wire logic                            presetn, // async reset
   input  wire logic                            run,     // detector runs
   input  wire logic                            raw_in,  // raw lock
   input  wire logic [aldfc_pkg::LOCK_CNT_W-1:0] limit,   // interval
   output var  logic                            q        // debounced
);
   import aldfc_pkg::*;

   typedef struct packed {
      logic [LOCK_CNT_W-1:0] cnt;
      logic                  q;
   } aldfc_deb_s;

   aldfc_deb_s st;
   aldfc_deb_s next_st;

   // any drop restarts the count from zero
   always_comb begin
      next_st = st;
      if (!run || !raw_in) begin
         next_st.cnt = '0;
         next_st.q   = 1'b0;
      end else if (st.cnt >= limit) begin
         next_st.q = 1'b1;
      end else begin
         next_st.cnt = st.cnt + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.q;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_rise_after_full;
      !st.q ##1 st.q |-> $past(st.cnt) >= $past(limit);
   endproperty
   a_rise_after_full: assert property (p_rise_after_full)
      else $error("lock rose before interval");
   property p_drop_clears;
      !raw_in |=> !st.q && st.cnt == '0;
   endproperty
   a_drop_clears: assert property (p_drop_clears)
      else $error("raw drop did not restart");
endmodule
`default_nettype wire

//--- src/aldfc_hold.sv
`timescale 1ns/10ps
`default_nettype none
module aldfc_hold (
   input  wire logic pclk,     // clock
   input  wire logic presetn,  // async reset
   input  wire logic disable_det, // detector disabled
   input  wire logic sticky,   // one-time lock
   input  wire logic deb_lock, // debounced lock
   output var  logic lock      // qualified lock
);
   typedef struct packed {
      logic lock;
   } aldfc_hold_s;

   aldfc_hold_s st;
   aldfc_hold_s next_st;

   // disable forces lock; sticky keeps it once set
   always_comb begin
      next_st = st;
      if (disable_det) begin
         next_st.lock = 1'b1;
      end else if (sticky && st.lock) begin
         next_st.lock = 1'b1;
      end else begin
         next_st.lock = deb_lock;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign lock = st.lock;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_sticky;
      sticky && st.lock && !disable_det |=> st.lock;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("one-time lock dropped");
   property p_realtime;
      !sticky && !disable_det |=> st.lock == $past(deb_lock);
   endproperty
   a_realtime: assert property (p_realtime)
      else $error("real-time lock not following");
   property p_disable;
      disable_det |=> st.lock;
   endproperty
   a_disable: assert property (p_disable)
      else $error("disabled detector not asserting");
endmodule
`default_nettype wire

//--- src/aldfc_pkg.sv
package aldfc_pkg;
   // ***************************************************
   // register byte offsets
   // ***************************************************
   localparam logic [7:0] OFF_LOOP_FILTER = 8'h00;
   localparam logic [7:0] OFF_THIRD_POLE  = 8'h04;
   localparam logic [7:0] OFF_LOCK_DET    = 8'h08;
   localparam logic [7:0] OFF_THRESH      = 8'h0C;
   localparam logic [7:0] OFF_STATUS      = 8'h10;

   // reset values and writable masks
   localparam logic [7:0]  RST_LOOP_FILTER = 8'h76;
   localparam logic [7:0]  RST_THIRD_POLE  = 8'h37;
   localparam logic [15:0] RST_LOCK_DET    = 16'h0180;
   localparam logic [7:0]  RST_THRESH      = 8'h88;
   localparam logic [7:0]  MASK_THIRD_POLE = 8'hF7;
   localparam logic [15:0] MASK_LOCK_DET   = 16'h03FF;

   // ***************************************************
   // field positions
   // ***************************************************
   localparam int CODE3_W         = 3;
   localparam int CODE4_W         = 4;
   localparam int LF_VCO_BYP_BIT  = 7;
   localparam int LF_CP_LSB       = 4;
   localparam int LF_RES_LSB      = 0;
   localparam int TP_BYP_BIT      = 7;
   localparam int TP_RES_LSB      = 4;
   localparam int TP_CAP_LSB      = 0;
   localparam int LD_RAW_PIN_BIT  = 9;
   localparam int LD_PREC_EN_BIT  = 8;
   localparam int LD_TIMER_LSB    = 6;
   localparam int LD_TIMER_W      = 2;
   localparam int LD_STICKY_BIT   = 5;
   localparam int LD_CALGATE_BIT  = 4;
   localparam int LD_DISABLE_BIT  = 3;
   localparam int LD_RC_LSB       = 0;
   localparam int TH_HIGH_LSB     = 4;
   localparam int TH_LOW_LSB      = 0;
   localparam int ST_LOCK_BIT     = 0;
   localparam int ST_RAW_BIT      = 1;
   localparam int ST_CAL_DONE_BIT = 2;
   localparam int ST_INT_MODE_BIT = 3;

   // ***************************************************
   // lock timer
   // ***************************************************
   localparam int          LOCK_CNT_W     = 16;
   localparam logic [15:0] LOCK_CYC_SHORT = 16'h023A; // 570 cycles
   localparam logic [1:0]  TMR_NONE       = 2'h0;
   localparam logic [1:0]  TMR_SHORT      = 2'h1;
   localparam logic [1:0]  TMR_MID        = 2'h2;
   localparam logic [1:0]  FB_ORDER_INT   = 2'h0;
endpackage

//--- src/aldfc_top.sv
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module aldfc_top #(
   parameter int unsigned LOCK_CYC_MID  = 5700,  // timer code 2
   parameter int unsigned LOCK_CYC_LONG = 57000  // timer code 3
) (
   input  wire logic        pclk,               // apb clock
   input  wire logic        presetn,            // async reset, low
   input  wire logic        psel,               // apb select
   input  wire logic        penable,            // apb enable
   input  wire logic        pwrite,             // apb direction
   input  wire logic [7:0]  paddr,              // apb byte address
   input  wire logic [31:0] pwdata,             // apb write data
   output var  logic [31:0] prdata,             // apb read data
   output var  logic        pready,             // apb ready
   output var  logic        pslverr,            // apb error
   input  wire logic        raw_lock_precision, // precision detector
   input  wire logic        raw_lock_original,  // original detector
   input  wire logic        vco_cal_done,       // calibration finished
   input  wire logic [1:0]  fb_sdm_order,       // feedback modulator
   output var  logic        lock_pin,           // status pin
   output var  logic        vco_filter_bypass,  // vco filter bypass
   output var  logic [2:0]  pole_capacitor_code,  // loop pole cap
   output var  logic [3:0]  loop_resistor_code,   // loop resistor
   output var  logic        third_pole_bypass,    // 3rd pole bypass
   output var  logic [2:0]  third_pole_resistor,  // 3rd pole res
   output var  logic [2:0]  third_pole_capacitor, // 3rd pole cap
   output var  logic        precision_lock_en,    // precision enable
   output var  logic [3:0]  precision_high_threshold, // high thresh
   output var  logic [3:0]  precision_low_threshold,  // low thresh
   output var  logic [2:0]  lock_rc_resistor      // lock rc res
);
   import aldfc_pkg::*;

   // ***************************************************
   // state
   // ***************************************************
   typedef struct packed {
      logic [7:0]  loop_filter;
      logic [7:0]  third_pole;
      logic [15:0] lock_det;
      logic [7:0]  thresh;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        lock_pin;
   } aldfc_regs_s;

   aldfc_regs_s st;
   aldfc_regs_s next_st;

   logic                  raw_sel;
   logic                  det_run;
   logic                  deb_lock;
   logic                  qual_lock;
   logic [LOCK_CNT_W-1:0] limit;
   logic                  setup;
   logic                  wr_go;
   logic [31:0]           rd_val;
   logic                  rd_hit;

   // ***************************************************
   // decode helpers
   // ***************************************************
   // timer code to cycle count; long counts are parameters
   function automatic logic [LOCK_CNT_W-1:0] timer_limit(
      input logic [1:0] code
   );
      logic [LOCK_CNT_W-1:0] r;
      r = LOCK_CNT_W'(LOCK_CYC_LONG);
      unique case (code)
         TMR_NONE:  r = '0;
         TMR_SHORT: r = LOCK_CYC_SHORT;
         TMR_MID:   r = LOCK_CNT_W'(LOCK_CYC_MID);
         default:   r = LOCK_CNT_W'(LOCK_CYC_LONG);
      endcase
      return r;
   endfunction

   // mapped-address check, shared by read and write paths
   function automatic logic addr_hit(input logic [7:0] a);
      return a == OFF_LOOP_FILTER || a == OFF_THIRD_POLE ||
             a == OFF_LOCK_DET || a == OFF_THRESH ||
             a == OFF_STATUS;
   endfunction

   // ***************************************************
   // lock path
   // ***************************************************
   // selected raw lock
   assign raw_sel = st.lock_det[LD_PREC_EN_BIT] ?
                    raw_lock_precision : raw_lock_original;

   // calibration gating of the detector
   assign det_run = st.lock_det[LD_CALGATE_BIT] | vco_cal_done;

   assign limit = timer_limit(
      st.lock_det[LD_TIMER_LSB +: LD_TIMER_W]);

   aldfc_debounce u_deb (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (det_run),
      .raw_in  (raw_sel),
      .limit   (limit),
      .q       (deb_lock)
   );

   aldfc_hold u_hold (
      .pclk        (pclk),
      .presetn     (presetn),
      .disable_det (st.lock_det[LD_DISABLE_BIT]),
      .sticky      (st.lock_det[LD_STICKY_BIT]),
      .deb_lock    (deb_lock),
      .lock        (qual_lock)
   );

   // ***************************************************
   // apb slave
   // ***************************************************
   // one wait-free access: ready is raised in setup so the
   // access phase always completes in a single cycle
   assign setup = psel && !penable;
   assign wr_go = psel && penable && st.pready && pwrite;

   // read mux; narrow registers sit in low bits
   always_comb begin
      rd_val = '0;
      rd_hit = addr_hit(paddr);
      unique case (paddr)
         OFF_LOOP_FILTER: rd_val[7:0]  = st.loop_filter;
         OFF_THIRD_POLE:  rd_val[7:0]  = st.third_pole;
         OFF_LOCK_DET:    rd_val[15:0] = st.lock_det;
         OFF_THRESH:      rd_val[7:0]  = st.thresh;
         OFF_STATUS: begin
            rd_val[ST_LOCK_BIT]     = qual_lock;
            rd_val[ST_RAW_BIT]      = raw_sel;
            rd_val[ST_CAL_DONE_BIT] = vco_cal_done;
            rd_val[ST_INT_MODE_BIT] =
               fb_sdm_order == FB_ORDER_INT;
         end
         default: rd_val = '0;
      endcase
   end

   // register updates, bus answer and pin select
   always_comb begin
      next_st = st;
      next_st.pready = setup;
      if (setup) begin
         next_st.pslverr = !rd_hit;
         next_st.prdata  = pwrite ? '0 : rd_val;
      end
      if (wr_go) begin
         unique case (paddr)
            OFF_LOOP_FILTER: next_st.loop_filter =
               pwdata[7:0];
            OFF_THIRD_POLE: next_st.third_pole =
               pwdata[7:0] & MASK_THIRD_POLE;
            OFF_LOCK_DET: next_st.lock_det =
               pwdata[15:0] & MASK_LOCK_DET;
            OFF_THRESH: next_st.thresh = pwdata[7:0];
            default: next_st.thresh = st.thresh;
         endcase
      end
      next_st.lock_pin = st.lock_det[LD_RAW_PIN_BIT] ?
                         raw_sel : qual_lock;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st             <= '0;
         st.loop_filter <= RST_LOOP_FILTER;
         st.third_pole  <= RST_THIRD_POLE;
         st.lock_det    <= RST_LOCK_DET;
         st.thresh      <= RST_THRESH;
      end else begin
         st <= next_st;
      end
   end

   // ***************************************************
   // outputs, all straight from state flops
   // ***************************************************
   // third-pole bypass is passed as written; integer mode
   // is software's duty, status shows it for checking
   assign prdata  = st.prdata;
   assign pready  = st.pready;
   assign pslverr = st.pslverr;
   assign lock_pin = st.lock_pin;
   assign vco_filter_bypass    = st.loop_filter[LF_VCO_BYP_BIT];
   assign pole_capacitor_code  =
      st.loop_filter[LF_CP_LSB +: CODE3_W];
   assign loop_resistor_code   =
      st.loop_filter[LF_RES_LSB +: CODE4_W];
   assign third_pole_bypass    = st.third_pole[TP_BYP_BIT];
   assign third_pole_resistor  =
      st.third_pole[TP_RES_LSB +: CODE3_W];
   assign third_pole_capacitor =
      st.third_pole[TP_CAP_LSB +: CODE3_W];
   assign precision_lock_en    = st.lock_det[LD_PREC_EN_BIT];
   assign precision_high_threshold =
      st.thresh[TH_HIGH_LSB +: CODE4_W];
   assign precision_low_threshold  =
      st.thresh[TH_LOW_LSB +: CODE4_W];
   assign lock_rc_resistor =
      st.lock_det[LD_RC_LSB +: CODE3_W];

   // ***************************************************
   // assertions
   // ***************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_raw_pin;
      st.lock_det[LD_RAW_PIN_BIT] ##1
         st.lock_det[LD_RAW_PIN_BIT] |=>
         lock_pin == $past(raw_sel);
   endproperty
   a_raw_pin: assert property (p_raw_pin)
      else $error("pin not showing raw lock");

   property p_prec_pick;
      st.lock_det[LD_PREC_EN_BIT] && st.lock_det[LD_RAW_PIN_BIT]
         |=> lock_pin == $past(raw_lock_precision);
   endproperty
   a_prec_pick: assert property (p_prec_pick)
      else $error("precision detector not selected");

   property p_code0_fast;
      (st.lock_det[LD_TIMER_LSB +: LD_TIMER_W] == TMR_NONE &&
         !st.lock_det[LD_DISABLE_BIT] && det_run && raw_sel) [*3]
         |-> deb_lock;
   endproperty
   a_code0_fast: assert property (p_code0_fast)
      else $error("zero interval still waiting");

   property p_cal_gate;
      !st.lock_det[LD_CALGATE_BIT] && !vco_cal_done |=> !deb_lock;
   endproperty
   a_cal_gate: assert property (p_cal_gate)
      else $error("detector ran during calibration");

   property p_pole_write;
      wr_go && paddr == OFF_LOOP_FILTER |=>
         pole_capacitor_code == $past(pwdata[6:4]) &&
         vco_filter_bypass == $past(pwdata[7]);
   endproperty
   a_pole_write: assert property (p_pole_write)
      else $error("loop filter write lost");

   property p_third_write;
      wr_go && paddr == OFF_THIRD_POLE |=>
         third_pole_resistor == $past(pwdata[6:4]) &&
         third_pole_capacitor == $past(pwdata[2:0]);
   endproperty
   a_third_write: assert property (p_third_write)
      else $error("third pole write lost");

   property p_bit3_zero;
      setup && !pwrite && paddr == OFF_THIRD_POLE |=> !prdata[3];
   endproperty
   a_bit3_zero: assert property (p_bit3_zero)
      else $error("reserved bit reads one");

   property p_rc_write;
      wr_go && paddr == OFF_LOCK_DET |=>
         lock_rc_resistor == $past(pwdata[2:0]);
   endproperty
   a_rc_write: assert property (p_rc_write)
      else $error("rc resistor write lost");

   property p_thr_write;
      wr_go && paddr == OFF_THRESH |=>
         precision_high_threshold == $past(pwdata[7:4]) &&
         precision_low_threshold == $past(pwdata[3:0]);
   endproperty
   a_thr_write: assert property (p_thr_write)
      else $error("threshold write lost");

   property p_status;
      setup && !pwrite && paddr == OFF_STATUS |=>
         prdata[ST_LOCK_BIT] == $past(qual_lock) && pready;
   endproperty
   a_status: assert property (p_status)
      else $error("status lock bit wrong");

   c_lock_seen: cover property (!qual_lock ##1 qual_lock);
   c_raw_pin: cover property (st.lock_det[LD_RAW_PIN_BIT] && lock_pin);
   c_err: cover property (pslverr && pready);
endmodule
`default_nettype wire

//--- verification/test_apll_lock_detect_and_filter_config.sv
`timescale 1ns/10ps
`default_nettype none
module test_apll_lock_detect_and_filter_config;
   import aldfc_pkg::*;

   // compare, count, and report at once; values shown in hex
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
   err_count++; $display("wrong value at %0t: got %h expected %h", \
   $time, got, exp); end end

   logic        pclk, presetn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rq;
   logic        pready, pslverr, re;
   logic        raw_lock_precision, raw_lock_original, vco_cal_done;
   logic [1:0]  fb_sdm_order;
   logic        lock_pin, vco_filter_bypass, third_pole_bypass;
   logic        precision_lock_en;
   logic [2:0]  pole_capacitor_code, third_pole_resistor;
   logic [2:0]  third_pole_capacitor, lock_rc_resistor;
   logic [3:0]  loop_resistor_code, precision_high_threshold;
   logic [3:0]  precision_low_threshold;
   int          err_count;
   int          n_compared;

   // short middle and long intervals keep the run brief
   aldfc_top #(.LOCK_CYC_MID(20), .LOCK_CYC_LONG(50)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .raw_lock_precision(raw_lock_precision),
      .raw_lock_original(raw_lock_original),
      .vco_cal_done(vco_cal_done), .fb_sdm_order(fb_sdm_order),
      .lock_pin(lock_pin), .vco_filter_bypass(vco_filter_bypass),
      .pole_capacitor_code(pole_capacitor_code),
      .loop_resistor_code(loop_resistor_code),
      .third_pole_bypass(third_pole_bypass),
      .third_pole_resistor(third_pole_resistor),
      .third_pole_capacitor(third_pole_capacitor),
      .precision_lock_en(precision_lock_en),
      .precision_high_threshold(precision_high_threshold),
      .precision_low_threshold(precision_low_threshold),
      .lock_rc_resistor(lock_rc_resistor));

   // ***************************************************
   // clock, closing and watchdog
   // ***************************************************
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic test_done;
      if (err_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // whole sequence needs about 850 cycles
   initial begin
      repeat (8000) @(posedge pclk);
      err_count++;
      test_done;
   end

   // ***************************************************
   // bus and timing tasks
   // ***************************************************
   // one transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rq = prdata;
      re = pslverr;
      if (k >= 50) err_count++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(rq, exp)
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // value seen at an edge is the one left by the previous edge,
   // so the pin shows up one edge after the documented walk
   task automatic lock_time(input int limit);
      int n;
      n = 0;
      @(posedge pclk);
      raw_lock_original <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (lock_pin !== 1'b1 && n < 700);
      `CHK(n, limit + 4)
   endtask

   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      err_count = 0;
      n_compared = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      raw_lock_precision = 1'b0;
      raw_lock_original = 1'b0;
      vco_cal_done = 1'b0;
      fb_sdm_order = 2'h0;
      cyc(3);
      presetn <= 1'b1;
      // reset values, at the ports and through the bus
      `CHK(pole_capacitor_code, 3'h7)
      `CHK(vco_filter_bypass, 1'b0)
      `CHK({third_pole_resistor, third_pole_capacitor}, 6'h1F)
      `CHK(lock_rc_resistor, 3'h0)
      `CHK(precision_lock_en, 1'b1)
      rd_chk(OFF_LOOP_FILTER, 32'h0000_0076);
      rd_chk(OFF_THIRD_POLE, 32'h0000_0037);
      rd_chk(OFF_LOCK_DET, 32'h0000_0180);
      rd_chk(OFF_THRESH, 32'h0000_0088);
      // field routing; bypass only while in integer divider mode
      apb(1'b1, OFF_LOOP_FILTER, 32'hFFFF_FFA5);
      apb(1'b1, OFF_THIRD_POLE, 32'hFFFF_FFDA);
      apb(1'b1, OFF_THRESH, 32'h0000_003C);
      apb(1'b1, OFF_LOCK_DET, 32'hFFFF_FFFF);
      // last write lands on the edge the task returns at; let it settle
      cyc(1);
      `CHK({vco_filter_bypass, pole_capacitor_code}, 4'hA)
      `CHK(loop_resistor_code, 4'h5)
      `CHK(third_pole_bypass, 1'b1)
      `CHK({third_pole_resistor, third_pole_capacitor}, 6'h2A)
      `CHK({precision_high_threshold, precision_low_threshold}, 8'h3C)
      `CHK(lock_rc_resistor, 3'h7)
      rd_chk(OFF_THIRD_POLE, 32'h0000_00D2);
      rd_chk(OFF_LOCK_DET, 32'h0000_03FF);
      // unmapped place: error flag, reads zero
      rd_chk(8'h14, 32'h0000_0000);
      `CHK(re, 1'b1)
      // every debounce code, original detector, calibration ignored
      apb(1'b1, OFF_LOCK_DET, 32'h0000_0010);
      // forced lock from the disable bit takes a few edges to drain
      cyc(3);
      lock_time(0);
      for (int c = 1; c < 4; c++) begin
         raw_lock_original <= 1'b0;
         apb(1'b1, OFF_LOCK_DET, (c << 6) | 32'h10);
         cyc(3);
         lock_time(c == 1 ? 570 : (c == 2 ? 20 : 50));
      end
      // a drop part way restarts the whole interval
      raw_lock_original <= 1'b0;
      apb(1'b1, OFF_LOCK_DET, 32'h0000_0090);
      raw_lock_original <= 1'b1;
      cyc(15);
      raw_lock_original <= 1'b0;
      `CHK(lock_pin, 1'b0)
      lock_time(20);
      // real time follows the loss; one-time mode holds it
      apb(1'b1, OFF_LOCK_DET, 32'h0000_0010);
      raw_lock_original <= 1'b0;
      cyc(5);
      `CHK(lock_pin, 1'b0)
      apb(1'b1, OFF_LOCK_DET, 32'h0000_0030);
      lock_time(0);
      raw_lock_original <= 1'b0;
      cyc(8);
      `CHK(lock_pin, 1'b1)
      // calibration gate: no lock until calibration completes
      apb(1'b1, OFF_LOCK_DET, 32'h0000_0000);
      raw_lock_original <= 1'b1;
      cyc(10);
      `CHK(lock_pin, 1'b0)
      vco_cal_done <= 1'b1;
      cyc(6);
      `CHK(lock_pin, 1'b1)
      // disabled detector holds lock with raw low; status reflects it
      raw_lock_original <= 1'b0;
      apb(1'b1, OFF_LOCK_DET, 32'h0000_0008);
      cyc(4);
      `CHK(lock_pin, 1'b1)
      rd_chk(OFF_STATUS, 32'h0000_000D);
      fb_sdm_order <= 2'h3;
      rd_chk(OFF_STATUS, 32'h0000_0005);
      // precision select against the original detector
      raw_lock_precision <= 1'b1;
      apb(1'b1, OFF_LOCK_DET, 32'h0000_0110);
      cyc(6);
      `CHK(lock_pin, 1'b1)
      apb(1'b1, OFF_LOCK_DET, 32'h0000_0010);
      cyc(6);
      `CHK(lock_pin, 1'b0)
      // raw to pin bypasses the long debounce
      raw_lock_precision <= 1'b0;
      apb(1'b1, OFF_LOCK_DET, 32'h0000_03D0);
      raw_lock_precision <= 1'b1;
      cyc(4);
      `CHK(lock_pin, 1'b1)
      raw_lock_precision <= 1'b0;
      cyc(4);
      `CHK(lock_pin, 1'b0)
      test_done;
   end
endmodule
`default_nettype wire
